// file: inc/resp_map.svh
// Constants of the text command responder: character codes,
// version reply text, lengths and buffer sizes.
// Assumes 8-bit characters, one per received or sent word.
`ifndef RESP_MAP_SVH
`define RESP_MAP_SVH

`define ASC_SPACE     8'h20
`define ASC_CR        8'h0D
`define ASC_LF        8'h0A
`define ASC_POINT     8'h2E
`define ASC_MINUS     8'h2D
`define ASC_DIGIT0    8'h30
`define ASC_A         8'h41
`define ASC_D         8'h44
`define ASC_E         8'h45
`define ASC_I         8'h49
`define ASC_L         8'h4C
`define ASC_S         8'h53
`define ASC_T         8'h54
`define ASC_Z         8'h5A
`define ASC_ONE       8'h31
`define ASC_K         8'h6B
`define ASC_G         8'h67
`define ASC_LB_L      8'h6C
`define ASC_LB_B      8'h62

// Command name slots kept in the line buffer
`define NAME_LEN      3
// Weight field width and digit count
`define FIELD_LEN     10
`define DIGITS        7
// Reply lengths, terminator included
`define LEN_WEIGHT    5'd19
`define LEN_ZERO      5'd5
`define LEN_ERR       5'd4
`define LEN_VER       6'd32
// Level and version reply text, terminator excluded
`define VER_TEXT      "I1 A \"1\" \"2.2x\" \"2.2x\" \" \" \" \""
`define VER_CHARS     30
// Transmit buffer
`define TXF_DEPTH     4
`define TXF_WIDTH     8

`endif

// file: inc/resp_pkg.sv
// Types used by the text command responder; its buffer uses none of them.
// Assumes resp_map.svh for all numeric constants.
`default_nettype none

package resp_pkg;

    typedef enum logic [1:0] {
        RSP_WEIGHT,
        RSP_ZERO,
        RSP_VERSION,
        RSP_ERR
    } resp_kind_e;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_STABLE,
        CMD_IMMEDIATE,
        CMD_ZERO,
        CMD_VERSION
    } cmd_e;

    typedef struct packed {
        logic [7:0] data;
        logic       par_err;
    } rx_char_s;

    typedef struct packed {
        resp_kind_e  kind;
        logic [15:0] err_id;
        logic [7:0]  status;
        logic [79:0] field;
        logic [15:0] unit;
    } resp_s;

endpackage

`default_nettype wire

// file: design/byte_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock, synchronous active-low reset, DEPTH a power of two.
`timescale 1ns/10ps
`default_nettype none

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;
    logic             full;
    logic             empty;

    assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                       (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign empty     = (wr_ptr_r == rd_ptr_r);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr_r[AW-1:0]];

    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
        end else if (in_valid && !full) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_ptr_r <= '0;
        end else if (out_ready && !empty) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end

endmodule

`default_nettype wire

// file: design/cmd_responder.sv
// Text command responder: collects a command line, decodes it and
// streams back one fixed-format reply through a small FIFO.
// Assumes characters arrive synchronous to SYS_CLK, one per
// RX_VALID and RX_READY cycle, with their parity check done outside.
`timescale 1ns/10ps
`default_nettype none
`include "resp_map.svh"

module cmd_responder (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  RX_DATA,
    input  wire logic        RX_PARITY_ERR,
    input  wire logic        RX_VALID,
    output logic             RX_READY,
    output logic      [7:0]  TX_DATA,
    output logic             TX_VALID,
    input  wire logic        TX_READY,
    input  wire logic [27:0] WEIGHT_BCD,
    input  wire logic        WEIGHT_NEG,
    input  wire logic [1:0]  WEIGHT_DP,
    input  wire logic        WEIGHT_STABLE,
    input  wire logic        UNIT_KG,
    input  wire logic        SCALE_BUSY,
    output logic             ZERO_REQ
);

    typedef enum logic {
        ST_COLLECT,
        ST_SEND
    } state_e;

    state_e              state_r;
    resp_pkg::rx_char_s  rx_c;
    resp_pkg::resp_s     resp_r;
    resp_pkg::resp_s     resp_nxt;
    resp_pkg::cmd_e      cmd;

    logic [7:0]  name_r [`NAME_LEN];
    logic [1:0]  name_cnt_r;
    logic        name_long_r;
    logic        in_param_r;
    logic        param_seen_r;
    logic        sep_bad_r;
    logic        last_space_r;
    logic        corrupt_r;
    logic        cr_seen_r;
    logic        take;
    logic        line_end;
    logic [5:0]  idx_r;
    logic [7:0]  push_data;
    logic        push_valid;
    logic        push_ready;
    logic        push_last;
    logic [7:0]  fifo_data;
    logic        fifo_valid;
    logic        fifo_pop;

    assign rx_c     = '{data: RX_DATA, par_err: RX_PARITY_ERR};
    assign take     = RX_VALID && RX_READY;
    assign line_end = take && cr_seen_r && (rx_c.data == `ASC_LF);

    // Formats the weight field right-justified with zero blanking
    function automatic logic [79:0] fmt_weight(
        input logic [27:0] bcd,
        input logic        neg,
        input logic [1:0]  dp
    );
        logic [79:0] f;
        int          msd;
        int          pos;
        f   = {`FIELD_LEN{`ASC_SPACE}};
        msd = int'(dp);
        for (int i = 0; i < `DIGITS; i++) begin
            if (bcd[4*i +: 4] != 4'h0 && i > int'(dp)) begin
                msd = i;
            end
        end
        for (int i = 0; i < `DIGITS; i++) begin
            pos = (dp != 2'h0 && i >= int'(dp)) ? i + 1 : i;
            if (i <= msd) begin
                f[8*pos +: 8] = `ASC_DIGIT0 | {4'h0, bcd[4*i +: 4]};
            end
        end
        if (dp != 2'h0) begin
            f[8*dp +: 8] = `ASC_POINT;
        end
        if (neg) begin
            pos = (dp != 2'h0) ? msd + 2 : msd + 1;
            f[8*pos +: 8] = `ASC_MINUS;
        end
        return f;
    endfunction

    // Number of characters in a reply of the given kind
    function automatic logic [5:0] resp_len(
        input resp_pkg::resp_kind_e kind
    );
        logic [5:0] n;
        case (kind)
            resp_pkg::RSP_WEIGHT:  n = {1'b0, `LEN_WEIGHT};
            resp_pkg::RSP_ZERO:    n = {1'b0, `LEN_ZERO};
            resp_pkg::RSP_VERSION: n = `LEN_VER;
            default:               n = {1'b0, `LEN_ERR};
        endcase
        return n;
    endfunction

    // Character at position idx of the reply held in r
    function automatic logic [7:0] resp_char(
        input resp_pkg::resp_s r,
        input logic [5:0]      idx
    );
        logic [7:0]       c;
        logic [8*30-1:0]  ver;
        int               k;
        c   = `ASC_SPACE;
        ver = `VER_TEXT;
        k   = int'(idx);
        if (idx == resp_len(r.kind) - 6'd2) begin
            c = `ASC_CR;
        end else if (idx == resp_len(r.kind) - 6'd1) begin
            c = `ASC_LF;
        end else begin
            case (r.kind)
                resp_pkg::RSP_WEIGHT: begin
                    if (k == 0) begin
                        c = `ASC_S;
                    end else if (k == 2) begin
                        c = r.status;
                    end else if (k >= 4 && k < 14) begin
                        c = r.field[8*(13-k) +: 8];
                    end else if (k == 15) begin
                        c = r.unit[15:8];
                    end else if (k == 16) begin
                        c = r.unit[7:0];
                    end
                end
                resp_pkg::RSP_ZERO: begin
                    if (k == 0) begin
                        c = `ASC_Z;
                    end else if (k == 2) begin
                        c = r.status;
                    end
                end
                resp_pkg::RSP_VERSION: begin
                    c = ver[8*(`VER_CHARS-1-k) +: 8];
                end
                default: begin
                    c = (k == 0) ? r.err_id[15:8] : r.err_id[7:0];
                end
            endcase
        end
        return c;
    endfunction

    // Name decode against the supported command set
    always_comb begin
        cmd = resp_pkg::CMD_NONE;
        if (!name_long_r) begin
            if (name_cnt_r == 2'd1 && name_r[0] == `ASC_S) begin
                cmd = resp_pkg::CMD_STABLE;
            end else if (name_cnt_r == 2'd2 && name_r[0] == `ASC_S &&
                         name_r[1] == `ASC_I) begin
                cmd = resp_pkg::CMD_IMMEDIATE;
            end else if (name_cnt_r == 2'd1 && name_r[0] == `ASC_Z) begin
                cmd = resp_pkg::CMD_ZERO;
            end else if (name_cnt_r == 2'd2 && name_r[0] == `ASC_I &&
                         name_r[1] == `ASC_ONE) begin
                cmd = resp_pkg::CMD_VERSION;
            end
        end
    end

    // Verdict on a complete line, highest fault first
    always_comb begin
        resp_nxt        = resp_r;
        resp_nxt.status = `ASC_A;
        resp_nxt.field  = fmt_weight(WEIGHT_BCD, WEIGHT_NEG, WEIGHT_DP);
        resp_nxt.unit   = UNIT_KG ? {`ASC_K, `ASC_G} :
                                    {`ASC_LB_L, `ASC_LB_B};
        resp_nxt.err_id = {`ASC_E, `ASC_S};
        resp_nxt.kind   = resp_pkg::RSP_ERR;
        if (corrupt_r || rx_c.par_err) begin
            resp_nxt.err_id = {`ASC_E, `ASC_T};
        end else if (cmd == resp_pkg::CMD_NONE) begin
            resp_nxt.err_id = {`ASC_E, `ASC_S};
        end else if (param_seen_r || sep_bad_r) begin
            resp_nxt.err_id = {`ASC_E, `ASC_L};
        end else if (SCALE_BUSY && cmd != resp_pkg::CMD_VERSION) begin
            resp_nxt.err_id = {`ASC_E, `ASC_I};
        end else if (cmd == resp_pkg::CMD_STABLE && !WEIGHT_STABLE) begin
            resp_nxt.err_id = {`ASC_E, `ASC_I};
        end else if (cmd == resp_pkg::CMD_ZERO) begin
            resp_nxt.kind = resp_pkg::RSP_ZERO;
        end else if (cmd == resp_pkg::CMD_VERSION) begin
            resp_nxt.kind = resp_pkg::RSP_VERSION;
        end else begin
            resp_nxt.kind   = resp_pkg::RSP_WEIGHT;
            resp_nxt.status = WEIGHT_STABLE ? `ASC_S : `ASC_D;
        end
    end

    // one reply per line, input held off meanwhile
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_r <= ST_COLLECT;
        end else if (state_r == ST_COLLECT && line_end) begin
            state_r <= ST_SEND;
        end else if (state_r == ST_SEND && push_last) begin
            state_r <= ST_COLLECT;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            RX_READY <= 1'b0;
        end else begin
            RX_READY <= (state_r == ST_COLLECT) && !line_end &&
                        !(state_r == ST_SEND && !push_last);
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            resp_r <= '0;
        end else if (line_end) begin
            resp_r <= resp_nxt;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ZERO_REQ <= 1'b0;
        end else begin
            ZERO_REQ <= line_end &&
                        resp_nxt.kind == resp_pkg::RSP_ZERO;
        end
    end

    // name slots of the line buffer
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            for (int i = 0; i < `NAME_LEN; i++) begin
                name_r[i] <= `ASC_SPACE;
            end
            name_cnt_r  <= 2'd0;
            name_long_r <= 1'b0;
        end else if (line_end) begin
            for (int i = 0; i < `NAME_LEN; i++) begin
                name_r[i] <= `ASC_SPACE;
            end
            name_cnt_r  <= 2'd0;
            name_long_r <= 1'b0;
        end else if (take && !in_param_r && rx_c.data != `ASC_SPACE &&
                     rx_c.data != `ASC_CR && rx_c.data != `ASC_LF) begin
            if (name_cnt_r == 2'(`NAME_LEN)) begin
                name_long_r <= 1'b1;
            end else begin
                name_r[name_cnt_r] <= rx_c.data;
                name_cnt_r         <= name_cnt_r + 2'd1;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || line_end) begin
            in_param_r   <= 1'b0;
            param_seen_r <= 1'b0;
            sep_bad_r    <= 1'b0;
            last_space_r <= 1'b0;
        end else if (take && rx_c.data != `ASC_CR &&
                     rx_c.data != `ASC_LF) begin
            last_space_r <= (rx_c.data == `ASC_SPACE);
            if (rx_c.data == `ASC_SPACE) begin
                in_param_r <= 1'b1;
                if (last_space_r || name_cnt_r == 2'd0) begin
                    sep_bad_r <= 1'b1;
                end
            end else if (in_param_r) begin
                param_seen_r <= 1'b1;
            end
        end else if (take && rx_c.data == `ASC_CR && last_space_r) begin
            sep_bad_r <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || line_end) begin
            corrupt_r <= 1'b0;
        end else if (take && (rx_c.par_err || rx_c.data[7])) begin
            corrupt_r <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || line_end) begin
            cr_seen_r <= 1'b0;
        end else if (take) begin
            cr_seen_r <= (rx_c.data == `ASC_CR);
        end
    end

    // reply characters streamed into the FIFO
    assign push_valid = (state_r == ST_SEND);
    assign push_data  = resp_char(resp_r, idx_r);
    assign push_last  = push_valid && push_ready &&
                        (idx_r == resp_len(resp_r.kind) - 6'd1);

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || state_r == ST_COLLECT) begin
            idx_r <= 6'd0;
        end else if (push_valid && push_ready) begin
            idx_r <= idx_r + 6'd1;
        end
    end

    byte_fifo #(
        .WIDTH (`TXF_WIDTH),
        .DEPTH (`TXF_DEPTH)
    ) u_tx_fifo (
        .clk       (SYS_CLK),
        .rst_n     (RST_N),
        .in_data   (push_data),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // Output register stage so the port comes from flops
    assign fifo_pop = fifo_valid && (!TX_VALID || TX_READY);

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            TX_VALID <= 1'b0;
            TX_DATA  <= 8'h00;
        end else if (!TX_VALID || TX_READY) begin
            TX_VALID <= fifo_valid;
            TX_DATA  <= fifo_data;
        end
    end

endmodule

`default_nettype wire

// file: testbench/resp_checker.sv
// Concurrent checks on the responder's receive, reply and zero ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
`include "resp_map.svh"

module resp_checker (
    input wire logic       SYS_CLK,
    input wire logic       RST_N,
    input wire logic [7:0] RX_DATA,
    input wire logic       RX_VALID,
    input wire logic       RX_READY,
    input wire logic [7:0] TX_DATA,
    input wire logic       TX_VALID,
    input wire logic       TX_READY,
    input wire logic       ZERO_REQ
);
    logic prev_cr_r;
    logic lf_take;

    // Line end is a taken LF right after a taken CR
    assign lf_take = RX_VALID && RX_READY && RX_DATA == `ASC_LF && prev_cr_r;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            prev_cr_r <= 1'b0;
        end else if (RX_VALID && RX_READY) begin
            prev_cr_r <= RX_DATA == `ASC_CR;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    a_rx_stop_line: assert property (lf_take |=> !RX_READY [*4])
        else $error("receive side open during reply");
    a_first_reply: assert property (lf_take |-> ##3 TX_VALID)
        else $error("reply not started three cycles after line end");
    a_tx_hold_stall: assert property (TX_VALID && !TX_READY |=>
        TX_VALID && $stable(TX_DATA)) else $error("reply character lost");
    a_cr_then_lf: assert property (TX_VALID && TX_READY &&
        TX_DATA == `ASC_CR |=> TX_VALID && TX_DATA == `ASC_LF)
        else $error("CR not followed by LF");
    a_tx_ascii_char: assert property (TX_VALID |->
        !TX_DATA[7] && TX_DATA != 8'h00) else $error("non text reply char");
    a_ready_hold: assert property (RX_READY && !RX_VALID |=> RX_READY)
        else $error("receive ready dropped without a take");
    a_ready_boot: assert property ($rose(RST_N) |-> ##[1:2] RX_READY)
        else $error("receive ready late after reset");
    a_zero_pulse: assert property (ZERO_REQ |=> !ZERO_REQ)
        else $error("zero request longer than one cycle");

    c_line_end: cover property (lf_take);
    c_zero: cover property (ZERO_REQ);
    c_stall: cover property (TX_VALID && !TX_READY);
endmodule

bind cmd_responder resp_checker i_chk (
    .SYS_CLK (SYS_CLK),
    .RST_N   (RST_N),
    .RX_DATA (RX_DATA),
    .RX_VALID(RX_VALID),
    .RX_READY(RX_READY),
    .TX_DATA (TX_DATA),
    .TX_VALID(TX_VALID),
    .TX_READY(TX_READY),
    .ZERO_REQ(ZERO_REQ)
);
`default_nettype wire

// file: testbench/host_model.sv
// Host side of the text link: sends command lines, collects replies.
// Assumes the caller enters send_line just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none

module host_model (
    input  wire logic       clk,
    output logic      [7:0] rx_data,
    output logic            rx_perr,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic       stall
);
    logic [7:0] got[$];
    logic [1:0] cnt;

    initial begin
        rx_data = 8'h00;
        rx_perr = 1'b0;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
        cnt = 2'h0;
    end

    // Stall passes one character in four
    always @(posedge clk) begin
        cnt <= cnt + 2'h1;
        tx_ready <= !stall || cnt == 2'h0;
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
    end

    task automatic send_line(input string s, input int bad);
        int i;
        logic [7:0] c;
        for (i = 0; i < s.len() + 2; i++) begin
            c = i < s.len() ? s[i] : (i == s.len() ? 8'h0D : 8'h0A);
            rx_data <= c;
            rx_perr <= i == bad;
            rx_valid <= 1'b1;
            do @(posedge clk); while (rx_ready !== 1'b1);
        end
        rx_valid <= 1'b0;
        rx_perr <= 1'b0;
        rx_data <= ~c;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: testbench/ascii_scale_command_responder_bench.sv
// Self-checking bench for the text command responder.
// Assumes host_model as far side and the checker bound to the design.
`timescale 1ns/10ps
`default_nettype none
`include "resp_map.svh"

module ascii_scale_command_responder_bench;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [27:0] wbcd = 28'h0000000;
    logic        wneg = 1'b0;
    logic [1:0]  wdp = 2'h0;
    logic        wstab = 1'b1;
    logic        ukg = 1'b1;
    logic        busy = 1'b0;
    logic        stall = 1'b0;
    wire  [7:0]  rx_data;
    wire  [7:0]  tx_data;
    wire         rx_perr, rx_valid, rx_ready, tx_valid, tx_ready, zero_req;
    int          err_count = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          zero_cnt = 0;
    string       eol = "\015\012";

    always #2 sys_clk = ~sys_clk;

    cmd_responder i_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .RX_DATA(rx_data),
        .RX_PARITY_ERR(rx_perr), .RX_VALID(rx_valid), .RX_READY(rx_ready),
        .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
        .WEIGHT_BCD(wbcd), .WEIGHT_NEG(wneg), .WEIGHT_DP(wdp),
        .WEIGHT_STABLE(wstab), .UNIT_KG(ukg), .SCALE_BUSY(busy),
        .ZERO_REQ(zero_req));
    host_model i_host (.clk(sys_clk), .rx_data(rx_data), .rx_perr(rx_perr),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .stall(stall));

    always @(posedge sys_clk) begin
        cyc++;
        if (rst_n && zero_req === 1'b1)
            zero_cnt++;
        if (cyc == 30000) begin
            err_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Right-justified ten wide, zeros blanked left of the kept digit
    function automatic string fld(logic [27:0] b, logic n, int d);
        string s;
        int i;
        logic lead;
        logic [3:0] g;
        s = "";
        lead = 1'b1;
        for (i = 6; i >= 0; i--) begin
            g = b[i*4+:4];
            if (!(lead && g == 4'h0 && i > d)) begin
                if (lead && n)
                    s = {s, "-"};
                lead = 1'b0;
                s = {s, string'(8'h30 + 8'(g))};
            end
            if (i == d && d != 0)
                s = {s, "."};
        end
        while (s.len() < 10)
            s = {" ", s};
        return s;
    endfunction

    // Whole reply, then nothing more for a while
    task automatic collect(input string exp);
        int i;
        int n;
        i = 0;
        while (i_host.got.size() < exp.len() && i < 600) begin
            @(posedge sys_clk);
            i++;
        end
        repeat (12) @(posedge sys_clk);
        n = i_host.got.size();
        chk(n, exp.len());
        for (i = 0; i < exp.len(); i++)
            chk(i < n ? i_host.got[i] : 8'hXX, exp[i]);
        i_host.got.delete();
    endtask

    task automatic setw(input logic [27:0] b, input logic n,
                        input logic [1:0] d, input logic s, input logic k);
        @(posedge sys_clk);
        wbcd <= b;
        wneg <= n;
        wdp <= d;
        wstab <= s;
        ukg <= k;
    endtask

    task automatic run(input string cmd, input int bad, input string exp);
        i_host.send_line(cmd, bad);
        collect(exp);
    endtask

    task automatic t_stable();
        setw(28'h0000256, 1'b0, 2'h3, 1'b1, 1'b1);
        run("S", -1, {"S S ", "     0.256", " kg", eol});
    endtask

    task automatic t_immediate();
        setw(28'h0012907, 1'b1, 2'h2, 1'b0, 1'b0);
        run("SI", -1, {"S D ", fld(28'h0012907, 1'b1, 2), " lb", eol});
        setw(28'h0000000, 1'b0, 2'h0, 1'b1, 1'b1);
        run("SI", -1, {"S S ", "         0", " kg", eol});
        setw(28'h9999999, 1'b1, 2'h1, 1'b1, 1'b1);
        run("SI", -1, {"S S ", fld(28'h9999999, 1'b1, 1), " kg", eol});
    endtask

    task automatic t_zero_version();
        int z;
        z = zero_cnt;
        run("Z", -1, {"Z A", eol});
        chk(zero_cnt - z, 1);
        run("I1", -1, {`VER_TEXT, eol});
    endtask

    // Lone CR inside a line and a bit-7 character are covered too
    task automatic t_errors();
        string cm[13] = '{"XYZ", "I5", "ZI", "s", "", "SIR", "S 1",
                          "Z 0", "I1 ", "S\015X", "SI", "XYZ", "S\351"};
        string id[13] = '{"ES", "ES", "ES", "ES", "ES", "ES", "EL",
                          "EL", "EL", "ES", "ET", "ET", "ET"};
        int bd[13] = '{-1, -1, -1, -1, -1, -1, -1, -1, -1, -1, 1, 0, -1};
        int i;
        // line ends only at CR LF
        for (i = 0; i < 13; i++)
            run(cm[i], bd[i], {id[i], eol});
    endtask

    task automatic t_busy();
        int z;
        z = zero_cnt;
        setw(28'h0000500, 1'b0, 2'h2, 1'b1, 1'b1);
        @(posedge sys_clk);
        busy <= 1'b1;
        run("S", -1, {"EI", eol});
        run("Z", -1, {"EI", eol});
        run("I1", -1, {`VER_TEXT, eol});
        chk(zero_cnt - z, 0);
        @(posedge sys_clk);
        busy <= 1'b0;
        wstab <= 1'b0;
        run("S", -1, {"EI", eol});
        @(posedge sys_clk);
        wstab <= 1'b1;
        run("S", -1, {"S S ", "      5.00", " kg", eol});
    endtask

    task automatic t_stall();
        setw(28'h0000042, 1'b0, 2'h0, 1'b1, 1'b0);
        @(posedge sys_clk);
        stall <= 1'b1;
        i_host.send_line("SI", -1);
        i_host.send_line("I1", -1);
        i_host.send_line("Q", -1);
        collect({"S S ", "        42", " lb", eol, `VER_TEXT, eol,
                 "ES", eol});
        @(posedge sys_clk);
        stall <= 1'b0;
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_stable();
        t_immediate();
        t_zero_version();
        t_errors();
        t_busy();
        t_stall();
        test_done();
    end
endmodule
`default_nettype wire
